// ---- core/uart9_pkg.sv ----
// Behaviour
// [RULE1] Timer one overflows per reload, prescale one/twelve
// [RULE2] Timer two counts sysclk/2, 16-bit reload
// [RULE3] Timer two independently clocks receive, transmit
// [RULE4] Clock select suppresses timer two interrupts
// [RULE5] Counter select clocks timer two from pin
// [RULE6] Frame: start, eight data LSB-first, ninth, stop
// [RULE7] Transmitter sends current ninth transmit bit
// [RULE8] Receiver captures ninth bit, ignores stop level
// [RULE9] Buffer write starts send; done at stop
// [RULE10] Receive only while receive enable set
// [RULE11] Accept only if done clear, filter passes
// [RULE12] Acceptance stores data, ninth bit, sets done
// [RULE13] Interrupt requested while either flag set
// [RULE14] Mode two rate sysclk/64 or sysclk/32
// [RULE15] Baud doubling resets to zero
// [RULE16] Mode three framing as two, timer rate
// [RULE17] Remote master marks addresses with ninth bit
// [RULE18] Filter mode interrupts only on address characters
// [RULE19] Timer one rate divides by 32 or 16
// [RULE20] Mode bits 10 select two, 11 three
// [RULE21] Only software clears the done flags
// [RULE22] Timer two rate divides by sixteen
package uart9_pkg;
	// ==========================================================
	// Clock and framing
	localparam int         CLK_HZ       = 10_000_000;
	localparam int         DATA_BITS    = 8;
	localparam int         FRAME_BITS   = 11;
	localparam int         OS_RATE      = 16;
	localparam logic [3:0] OS_LAST      = 4'(OS_RATE - 1);
	localparam logic [3:0] OS_HALF      = 4'(OS_RATE / 2 - 1);
	localparam logic [3:0] TX_STOP_IDX  = 4'(FRAME_BITS - 1);
	localparam logic [3:0] TX_LAST_IDX  = 4'(FRAME_BITS - 1);
	localparam logic [3:0] RX_NINTH_IDX = 4'(DATA_BITS);
	// ==========================================================
	// Baud sources
	localparam int         T1_PRESCALE  = 12;
	localparam logic [3:0] T1_PRE_LAST  = 4'(T1_PRESCALE - 1);
	localparam logic [7:0] T1_TOP       = 8'hFF;
	localparam logic [15:0] T2_TOP      = 16'hFFFF;
	localparam int         M2_DIV_SLOW  = 64;
	localparam int         M2_DIV_FAST  = 32;
	localparam logic [1:0] M2_LAST_SLOW = 2'(M2_DIV_SLOW / OS_RATE - 1);
	localparam logic [1:0] M2_LAST_FAST = 2'(M2_DIV_FAST / OS_RATE - 1);
	localparam logic [1:0] MODE_TWO     = 2'h2;
	localparam logic [1:0] MODE_THREE   = 2'h3;
	// ==========================================================
	// Reset values and buffering
	localparam logic       BAUD_DOUBLE_RST = 1'b0;
	localparam logic [7:0] BUF_RST         = 8'h00;
	localparam int         FIFO_DEPTH      = 16;
	// ==========================================================
	// State machines
	typedef enum logic {TX_IDLE = 1'b0, TX_SEND = 1'b1} tx_state_t;
	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_START = 2'b01,
		RX_DATA  = 2'b11,
		RX_STOP  = 2'b10
	} rx_state_t;
endpackage

// ---- core/uart9_if.sv ----
// Timer overflow pulses from the baud generator
interface baud_if;
	logic t1_ovf;
	logic t2_ovf;
	modport gen (output t1_ovf, output t2_ovf);
	modport use_side (input t1_ovf, input t2_ovf);
endinterface

// Valid/ready stream between buffer and transmitter
interface stream_if #(parameter int WIDTH = 8);
	logic [WIDTH-1:0] data;
	logic             valid;
	logic             ready;
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface

// ---- core/uart9_fifo.sv ----
module uart9_fifo
	import uart9_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rst_b,
	// Fill side
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready_reg,
	// Drain side
	stream_if.src                 out
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic             push;
	logic             pop;

	// Handshakes on both sides
	assign push      = in_valid && in_ready_reg;
	assign pop       = out.valid && out.ready;
	assign out.data  = mem_reg[rd_ptr_reg];
	assign out.valid = (count_reg != '0);

	// Storage write
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data;
		end
	end

	// Pointers, fill level and registered ready
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			wr_ptr_reg   <= '0;
			rd_ptr_reg   <= '0;
			count_reg    <= '0;
			in_ready_reg <= 1'b1;
		end else begin
			if (push) begin
				wr_ptr_reg <= AW'((32'(wr_ptr_reg) + 1) % DEPTH);
			end
			if (pop) begin
				rd_ptr_reg <= AW'((32'(rd_ptr_reg) + 1) % DEPTH);
			end
			if (push && !pop) begin
				count_reg    <= count_reg + 1'b1;
				in_ready_reg <= (32'(count_reg) + 1 < DEPTH);
			end else if (pop && !push) begin
				count_reg    <= count_reg - 1'b1;
				in_ready_reg <= 1'b1;
			end
		end
	end
endmodule

// ---- core/uart9_baud.sv ----
module uart9_baud
	import uart9_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	// Timer one setup
	input  wire logic        timer1_tick_select,
	input  wire logic [7:0]  reload_hi,
	// Timer two setup
	input  wire logic        t2_run,
	input  wire logic        t2_counter_select,
	input  wire logic [7:0]  t2_reload_high,
	input  wire logic [7:0]  t2_reload_low,
	input  wire logic        t2_ext_pin,
	// Overflow pulses
	baud_if.gen              ovf
);
	logic [3:0]  pre_reg;
	logic [7:0]  t1_reg;
	logic        t1_ovf_reg;
	logic [15:0] t2_reg;
	logic        t2_ovf_reg;
	logic        half_reg;
	logic [2:0]  pin_sync_reg;
	logic        t1_tick;
	logic        t2_tick;

	assign ovf.t1_ovf = t1_ovf_reg;
	assign ovf.t2_ovf = t2_ovf_reg;

	// Timer one tick: every clock or every twelfth
	assign t1_tick = timer1_tick_select || (pre_reg == T1_PRE_LAST); // [RULE1]

	// Timer two tick: half clock or falling edge on pin
	assign t2_tick = t2_counter_select ? (pin_sync_reg[2] && !pin_sync_reg[1]) // [RULE5]
		: half_reg; // [RULE2]

	// Prescaler and half-rate toggle
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			pre_reg  <= '0;
			half_reg <= 1'b0;
		end else begin
			pre_reg  <= (pre_reg == T1_PRE_LAST) ? 4'h0 : pre_reg + 4'h1;
			half_reg <= !half_reg;
		end
	end

	// Pin synchroniser, third stage for edge detect
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			pin_sync_reg <= 3'h7;
		end else begin
			pin_sync_reg <= {pin_sync_reg[1:0], t2_ext_pin};
		end
	end

	// Timer one 8-bit auto-reload
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			t1_reg     <= '0;
			t1_ovf_reg <= 1'b0;
		end else begin
			t1_ovf_reg <= t1_tick && (t1_reg == T1_TOP);
			if (t1_tick) begin
				t1_reg <= (t1_reg == T1_TOP) ? reload_hi : t1_reg + 8'h01; // [RULE1]
			end
		end
	end

	// Timer two 16-bit auto-reload, baud generator only
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			t2_reg     <= '0;
			t2_ovf_reg <= 1'b0;
		end else begin
			t2_ovf_reg <= t2_run && t2_tick && (t2_reg == T2_TOP);
			// Parked at the reload while idle, so the first period is a full one
			if (!t2_run) begin
				t2_reg <= {t2_reload_high, t2_reload_low};
			end else if (t2_tick) begin
				t2_reg <= (t2_reg == T2_TOP) ? {t2_reload_high, t2_reload_low} // [RULE2]
					: t2_reg + 16'h0001;
			end
		end
	end
endmodule

// ---- core/uart9_top.sv ----
module uart9_top
	import uart9_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst_b,
	// Mode and rate control
	input  wire logic       mode_sel_hi,
	input  wire logic       mode_sel_lo,
	input  wire logic       baud_double,
	input  wire logic       timer1_tick_select,
	input  wire logic [7:0] reload_hi,
	input  wire logic       rx_clock_select,
	input  wire logic       tx_clock_select,
	input  wire logic       t2_counter_select,
	input  wire logic [7:0] t2_reload_high,
	input  wire logic [7:0] t2_reload_low,
	input  wire logic       t2_ext_pin,
	// Serial control bits
	input  wire logic       address_filter_mode,
	input  wire logic       rx_enable,
	input  wire logic       ninth_tx_bit,
	input  wire logic       tx_done_clr,
	input  wire logic       rx_done_clr,
	input  wire logic       serial_int_enable,
	// Transmit buffer write
	input  wire logic [7:0] serial_buffer_wr_data,
	input  wire logic       serial_buffer_wr,
	output logic            serial_buffer_wr_ready,
	// Receive side and status
	output logic [7:0]      serial_buffer_rx_reg,
	output logic            ninth_rx_bit_reg,
	output logic            tx_done_flag_reg,
	output logic            rx_done_flag_reg,
	output logic            serial_irq_reg,
	output logic            t2_irq_block_reg,
	output logic            tx_busy_reg,
	output logic            baud_double_reg,
	// Serial pins
	input  wire logic       rx_pin,
	output logic            tx_pin_reg
);
	// ==========================================================
	// Declarations
	baud_if            bif ();
	stream_if #(.WIDTH(DATA_BITS)) txq ();
	tx_state_t         tx_state_reg;
	rx_state_t         rx_state_reg;
	logic [1:0]        mode;
	logic              mode_nine;
	logic [1:0]        rx_m2_reg;
	logic [1:0]        tx_m2_reg;
	logic              t1_half_reg;
	logic              t1_os;
	logic              rx_tick;
	logic              tx_tick;
	logic [FRAME_BITS-1:0] tx_shift_reg;
	logic [3:0]        tx_sub_reg;
	logic [3:0]        tx_idx_reg;
	logic              tx_load;
	logic              tx_set;
	logic [1:0]        rx_sync_reg;
	logic [3:0]        rx_sub_reg;
	logic [3:0]        rx_idx_reg;
	logic [DATA_BITS:0] rx_shift_reg;
	logic              rx_accept;
	logic              rx_set;

	// Mode decode: only 9-bit modes run here
	assign mode      = {mode_sel_hi, mode_sel_lo};
	assign mode_nine = (mode == MODE_TWO) || (mode == MODE_THREE); // [RULE20]

	// ==========================================================
	// Baud generation
	uart9_baud u_baud (
		.clk_sys            (clk_sys),
		.rst_b              (rst_b),
		.timer1_tick_select (timer1_tick_select),
		.reload_hi          (reload_hi),
		.t2_run             (rx_clock_select || tx_clock_select), // [RULE4]
		.t2_counter_select  (t2_counter_select),
		.t2_reload_high     (t2_reload_high),
		.t2_reload_low      (t2_reload_low),
		.t2_ext_pin         (t2_ext_pin),
		.ovf                (bif.gen)
	);

	// Doubling latch, timer one halving and mode two dividers
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			baud_double_reg <= BAUD_DOUBLE_RST; // [RULE15]
			t1_half_reg     <= 1'b0;
			rx_m2_reg       <= '0;
			tx_m2_reg       <= '0;
		end else begin
			baud_double_reg <= baud_double;
			if (bif.t1_ovf) begin
				t1_half_reg <= !t1_half_reg;
			end
			rx_m2_reg <= rx_tick ? 2'h0 : rx_m2_reg + 2'h1;
			tx_m2_reg <= tx_tick ? 2'h0 : tx_m2_reg + 2'h1;
		end
	end

	// Timer one oversample tick: every overflow, or every second
	assign t1_os = bif.t1_ovf && (baud_double_reg || t1_half_reg); // [RULE19]

	// Oversample ticks per direction
	function automatic logic os_tick(input logic [1:0] md, input logic dbl, input logic sel_t2,
		input logic [1:0] m2cnt, input logic t2o, input logic t1o);
		if (md == MODE_TWO) begin
			os_tick = (m2cnt >= (dbl ? M2_LAST_FAST : M2_LAST_SLOW)); // [RULE14]
		end else begin
			os_tick = sel_t2 ? t2o : t1o; // [RULE16] [RULE22]
		end
	endfunction

	// Every source passed in; outside mode two each tick follows only the overflow that its own clock select picks
	assign rx_tick = os_tick(mode, baud_double_reg, rx_clock_select, rx_m2_reg,
		bif.t2_ovf, t1_os); // [RULE3]
	assign tx_tick = os_tick(mode, baud_double_reg, tx_clock_select, tx_m2_reg,
		bif.t2_ovf, t1_os); // [RULE3]

	// Timer two interrupt suppression while it clocks the port
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			t2_irq_block_reg <= 1'b0;
		end else begin
			t2_irq_block_reg <= rx_clock_select || tx_clock_select; // [RULE4]
		end
	end

	// ==========================================================
	// Transmit buffer
	uart9_fifo #(.WIDTH(DATA_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_sys      (clk_sys),
		.rst_b        (rst_b),
		.in_data      (serial_buffer_wr_data),
		.in_valid     (serial_buffer_wr), // [RULE9]
		.in_ready_reg (serial_buffer_wr_ready),
		.out          (txq.src)
	);

	assign tx_load   = (tx_state_reg == TX_IDLE) && mode_nine && txq.valid && tx_tick;
	assign txq.ready = tx_load;

	// Transmitter sequencing
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			tx_state_reg <= TX_IDLE;
			tx_shift_reg <= '1;
			tx_sub_reg   <= '0;
			tx_idx_reg   <= '0;
		end else begin
			unique case (tx_state_reg)
				TX_IDLE: begin
					if (tx_load) begin
						tx_shift_reg <= {1'b1, ninth_tx_bit, txq.data, 1'b0}; // [RULE6] [RULE7]
						tx_sub_reg   <= '0;
						tx_idx_reg   <= '0;
						tx_state_reg <= TX_SEND;
					end
				end
				TX_SEND: begin
					if (tx_tick) begin
						tx_sub_reg <= tx_sub_reg + 4'h1;
						if (tx_sub_reg == OS_LAST) begin
							tx_shift_reg <= {1'b1, tx_shift_reg[FRAME_BITS-1:1]}; // [RULE6]
							tx_idx_reg   <= tx_idx_reg + 4'h1;
							if (tx_idx_reg == TX_LAST_IDX) begin
								tx_state_reg <= TX_IDLE;
							end
						end
					end
				end
			endcase
		end
	end

	// Done raised as the stop bit begins
	assign tx_set = (tx_state_reg == TX_SEND) && tx_tick && (tx_sub_reg == OS_LAST)
		&& (tx_idx_reg == TX_STOP_IDX - 4'h1); // [RULE9]

	// Line driver and busy indication
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			tx_pin_reg  <= 1'b1;
			tx_busy_reg <= 1'b0;
		end else begin
			tx_pin_reg  <= (tx_state_reg == TX_SEND) ? tx_shift_reg[0] : 1'b1;
			tx_busy_reg <= (tx_state_reg == TX_SEND) || txq.valid;
		end
	end

	// ==========================================================
	// Receiver
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			rx_sync_reg <= 2'h3;
		end else begin
			rx_sync_reg <= {rx_sync_reg[0], rx_pin};
		end
	end

	// Receive sequencing, sampled mid-bit at 16x
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			rx_state_reg <= RX_IDLE;
			rx_sub_reg   <= '0;
			rx_idx_reg   <= '0;
			rx_shift_reg <= '0;
		end else if (rx_tick) begin
			rx_sub_reg <= rx_sub_reg + 4'h1;
			unique case (rx_state_reg)
				RX_IDLE: begin
					rx_sub_reg <= '0;
					if (rx_enable && mode_nine && !rx_sync_reg[1]) begin // [RULE10]
						rx_state_reg <= RX_START;
					end
				end
				RX_START: begin
					if (rx_sub_reg == OS_HALF) begin
						rx_sub_reg   <= '0;
						rx_idx_reg   <= '0;
						rx_state_reg <= rx_sync_reg[1] ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: begin
					if (rx_sub_reg == OS_LAST) begin
						rx_shift_reg <= {rx_sync_reg[1], rx_shift_reg[DATA_BITS:1]}; // [RULE6]
						rx_idx_reg   <= rx_idx_reg + 4'h1;
						if (rx_idx_reg == RX_NINTH_IDX) begin
							rx_state_reg <= RX_STOP;
						end
					end
				end
				RX_STOP: begin
					if (rx_sub_reg == OS_LAST) begin
						rx_state_reg <= RX_IDLE; // [RULE8]
					end
				end
			endcase
		end
	end

	// Acceptance at mid-stop; stop level deliberately unchecked
	assign rx_accept = (rx_state_reg == RX_STOP) && rx_tick && (rx_sub_reg == OS_LAST)
		&& !rx_done_flag_reg // [RULE11]
		&& (!address_filter_mode || rx_shift_reg[DATA_BITS]); // [RULE11] [RULE18]
	assign rx_set = rx_accept;

	// Receive buffer and ninth bit load
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			serial_buffer_rx_reg <= BUF_RST;
			ninth_rx_bit_reg     <= 1'b0;
		end else if (rx_accept) begin
			serial_buffer_rx_reg <= rx_shift_reg[DATA_BITS-1:0]; // [RULE12]
			ninth_rx_bit_reg     <= rx_shift_reg[DATA_BITS]; // [RULE8] [RULE12]
		end
	end

	// ==========================================================
	// Flags and interrupt request; a set beats a clear
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			tx_done_flag_reg <= 1'b0;
			rx_done_flag_reg <= 1'b0;
			serial_irq_reg   <= 1'b0;
		end else begin
			tx_done_flag_reg <= tx_set || (tx_done_flag_reg && !tx_done_clr); // [RULE21]
			rx_done_flag_reg <= rx_set || (rx_done_flag_reg && !rx_done_clr); // [RULE12] [RULE21]
			serial_irq_reg   <= serial_int_enable
				&& (tx_done_flag_reg || rx_done_flag_reg); // [RULE13]
		end
	end
endmodule

// ---- dv/uart9_monitor.sv ----
// ==========================================
// Port checker for the nine-bit serial block
module uart9_monitor
	import uart9_pkg::*;
(
	// Clock and reset
	input wire logic       clk_sys,
	input wire logic       rst_b,
	// Control inputs
	input wire logic       mode_sel_hi,
	input wire logic       rx_clock_select,
	input wire logic       tx_clock_select,
	input wire logic       address_filter_mode,
	input wire logic       rx_enable,
	input wire logic       tx_done_clr,
	input wire logic       rx_done_clr,
	input wire logic       serial_int_enable,
	// Outputs watched
	input wire logic       serial_buffer_wr_ready,
	input wire logic [7:0] serial_buffer_rx_reg,
	input wire logic       ninth_rx_bit_reg,
	input wire logic       tx_done_flag_reg,
	input wire logic       rx_done_flag_reg,
	input wire logic       serial_irq_reg,
	input wire logic       t2_irq_block_reg,
	input wire logic       tx_busy_reg,
	input wire logic       baud_double_reg,
	input wire logic       tx_pin_reg
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	// Interrupt request tracks enabled flags one clock late
	property p_irq;
		serial_irq_reg == $past(serial_int_enable && (tx_done_flag_reg || rx_done_flag_reg));
	endproperty
	// Timer two interrupts blocked while it clocks the port
	property p_blk;
		(rx_clock_select || tx_clock_select) |=> t2_irq_block_reg;
	endproperty
	// Slow rate selected after reset
	property p_dbl;
		$rose(rst_b) |-> !baud_double_reg;
	endproperty
	// Held character untouched while receive flag stands
	property p_rx_keep;
		rx_done_flag_reg && !rx_done_clr |=> rx_done_flag_reg
			&& $stable(serial_buffer_rx_reg) && $stable(ninth_rx_bit_reg);
	endproperty
	// Transmit flag only falls after a software clear
	property p_tx_fall;
		$fell(tx_done_flag_reg) |-> $past(tx_done_clr);
	endproperty
	// Filter passes only address characters
	property p_filt;
		$rose(rx_done_flag_reg) && address_filter_mode |-> ninth_rx_bit_reg;
	endproperty
	// No reception while receiver disabled
	property p_rxen;
		$rose(rx_done_flag_reg) |-> $past(rx_enable);
	endproperty
	// Modes other than two and three keep the line idle
	property p_idle;
		!mode_sel_hi |-> tx_pin_reg;
	endproperty
	// Transmit flag coincides with the high stop bit
	property p_stop;
		$rose(tx_done_flag_reg) |-> ##[0:1] tx_pin_reg;
	endproperty
	// Line idles high between characters
	property p_quiet;
		!tx_busy_reg |-> tx_pin_reg;
	endproperty
	a_irq: assert property (p_irq) else $error("irq mismatch");
	a_blk: assert property (p_blk) else $error("t2 block low");
	a_dbl: assert property (p_dbl) else $error("double not reset");
	a_rx_keep: assert property (p_rx_keep) else $error("rx overwritten");
	a_tx_fall: assert property (p_tx_fall) else $error("tx flag cleared");
	a_filt: assert property (p_filt) else $error("filter leak");
	a_rxen: assert property (p_rxen) else $error("rx while disabled");
	a_idle: assert property (p_idle) else $error("idle mode sent");
	a_stop: assert property (p_stop) else $error("flag before stop");
	a_quiet: assert property (p_quiet) else $error("idle line low");
	// Main scenarios reached
	c_rx: cover property ($rose(rx_done_flag_reg));
	c_tx: cover property ($rose(tx_done_flag_reg));
	c_full: cover property (!serial_buffer_wr_ready);
	c_t2: cover property (t2_irq_block_reg);
endmodule

bind uart9_top uart9_monitor i_uart9_monitor (
	.clk_sys(clk_sys), .rst_b(rst_b), .mode_sel_hi(mode_sel_hi),
	.rx_clock_select(rx_clock_select), .tx_clock_select(tx_clock_select),
	.address_filter_mode(address_filter_mode), .rx_enable(rx_enable),
	.tx_done_clr(tx_done_clr), .rx_done_clr(rx_done_clr),
	.serial_int_enable(serial_int_enable), .serial_buffer_wr_ready(serial_buffer_wr_ready),
	.serial_buffer_rx_reg(serial_buffer_rx_reg), .ninth_rx_bit_reg(ninth_rx_bit_reg),
	.tx_done_flag_reg(tx_done_flag_reg), .rx_done_flag_reg(rx_done_flag_reg),
	.serial_irq_reg(serial_irq_reg), .t2_irq_block_reg(t2_irq_block_reg),
	.tx_busy_reg(tx_busy_reg), .baud_double_reg(baud_double_reg), .tx_pin_reg(tx_pin_reg)
);

// ---- dv/uart9_remote.sv ----
// ==========================================
// Remote node on the serial line
module uart9_remote (
	// Clock and serial lines
	input  wire logic clk_sys,
	input  wire logic tx_pin,
	output logic      rx_pin,
	// Bit lengths in clocks
	input  var int    send_clks,
	input  var int    recv_clks
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [9:0] got_q[$];
	logic [9:0] sh;
	initial rx_pin = 1'b1;
	// Frame out: start, data LSB first, ninth, stop; line marks high after
	task automatic send(input logic [8:0] ch, input logic stp);
		logic [10:0] f;
		f = {stp, ch, 1'b0};
		@(posedge clk_sys);
		#1;
		for (int i = 0; i < 11; i++) begin
			rx_pin = f[i];
			repeat (send_clks) @(posedge clk_sys);
			#1;
		end
		rx_pin = 1'b1;
	endtask
	// Frame in: mid-bit samples on the falling clock, stop kept on top
	always begin
		@(negedge tx_pin);
		repeat (recv_clks / 2) @(negedge clk_sys);
		for (int i = 0; i < 10; i++) begin
			repeat (recv_clks) @(negedge clk_sys);
			sh[i] = tx_pin;
		end
		got_q.push_back(sh);
	end
endmodule

// ---- dv/uart9_top_tb.sv ----
// ==========================================
// Self-checking bench for the nine-bit serial block
module uart9_top_tb
	import uart9_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic m3, dbl, tick; logic [7:0] rl; logic rc, tc, cs;
		logic [15:0] t2; int txc, rxc;} row_t;
	logic       clk_sys = 1'b0, rst_b = 1'b0, mode_sel_hi = 1'b1, mode_sel_lo = 1'b0;
	logic       baud_double = 1'b1, timer1_tick_select = 1'b1, rx_clock_select = 1'b0;
	logic       tx_clock_select = 1'b0, t2_counter_select = 1'b0, address_filter_mode = 1'b0;
	logic       rx_enable = 1'b1, ninth_tx_bit = 1'b0, tx_done_clr = 1'b0, rx_done_clr = 1'b0;
	logic       serial_int_enable = 1'b1, serial_buffer_wr = 1'b0;
	logic [7:0] reload_hi = 8'hFF, t2_reload_high = 8'hFF, t2_reload_low = 8'hFF;
	logic [7:0] serial_buffer_wr_data = 8'h00, serial_buffer_rx_reg, b;
	logic       serial_buffer_wr_ready, ninth_rx_bit_reg, tx_done_flag_reg, rx_done_flag_reg;
	logic       serial_irq_reg, t2_irq_block_reg, tx_busy_reg, baud_double_reg, tx_pin_reg, rx_pin;
	logic [1:0] ext_div = 2'h0;
	int         err_count = 0, check_count = 0, send_clks = 32, recv_clks = 32;
	row_t       r;
	row_t       rows[8] = '{
		'{1'b0, 1'b0, 1'b1, 8'hFF, 1'b0, 1'b0, 1'b0, 16'hFFFF, 64, 64},
		'{1'b0, 1'b1, 1'b1, 8'hFF, 1'b0, 1'b0, 1'b0, 16'hFFFF, 32, 32},
		'{1'b1, 1'b1, 1'b1, 8'hFF, 1'b0, 1'b0, 1'b0, 16'hFFFF, 16, 16},
		'{1'b1, 1'b1, 1'b0, 8'hFF, 1'b0, 1'b0, 1'b0, 16'hFFFF, 192, 192},
		'{1'b1, 1'b0, 1'b1, 8'hFE, 1'b0, 1'b0, 1'b0, 16'hFFFF, 64, 64},
		'{1'b1, 1'b1, 1'b1, 8'hFF, 1'b0, 1'b1, 1'b0, 16'hFFFF, 32, 16},
		'{1'b1, 1'b1, 1'b1, 8'hFF, 1'b1, 1'b0, 1'b0, 16'hFFFE, 16, 64},
		'{1'b1, 1'b1, 1'b1, 8'hFF, 1'b1, 1'b1, 1'b1, 16'hFFFF, 64, 64}};
	// Clock and external timer input, a fall every four clocks
	always #50 clk_sys = ~clk_sys;
	always @(posedge clk_sys) ext_div <= ext_div + 2'h1;
	// ==========================================
	// Design and remote node
	uart9_top i_uart9_top (.clk_sys(clk_sys), .rst_b(rst_b), .mode_sel_hi(mode_sel_hi),
		.mode_sel_lo(mode_sel_lo), .baud_double(baud_double), .reload_hi(reload_hi),
		.timer1_tick_select(timer1_tick_select), .rx_clock_select(rx_clock_select),
		.tx_clock_select(tx_clock_select), .t2_counter_select(t2_counter_select),
		.t2_reload_high(t2_reload_high), .t2_reload_low(t2_reload_low), .t2_ext_pin(ext_div[1]),
		.address_filter_mode(address_filter_mode), .rx_enable(rx_enable),
		.ninth_tx_bit(ninth_tx_bit), .tx_done_clr(tx_done_clr), .rx_done_clr(rx_done_clr),
		.serial_int_enable(serial_int_enable), .serial_buffer_wr_data(serial_buffer_wr_data),
		.serial_buffer_wr(serial_buffer_wr), .serial_buffer_wr_ready(serial_buffer_wr_ready),
		.serial_buffer_rx_reg(serial_buffer_rx_reg), .ninth_rx_bit_reg(ninth_rx_bit_reg),
		.tx_done_flag_reg(tx_done_flag_reg), .rx_done_flag_reg(rx_done_flag_reg),
		.serial_irq_reg(serial_irq_reg), .t2_irq_block_reg(t2_irq_block_reg),
		.tx_busy_reg(tx_busy_reg), .baud_double_reg(baud_double_reg), .rx_pin(rx_pin),
		.tx_pin_reg(tx_pin_reg));
	uart9_remote i_uart9_remote (.clk_sys(clk_sys), .tx_pin(tx_pin_reg), .rx_pin(rx_pin),
		.send_clks(send_clks), .recv_clks(recv_clks));
	// ==========================================
	// Access tasks
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic check(input logic [9:0] seen, input logic [9:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Bounded wait: 0 transmit flag, 1 transmitter idle, 2 remote got a character
	task automatic wait_on(input int sel);
		int k;
		for (k = 0; k < 20000; k++) begin
			if (sel == 0 && tx_done_flag_reg === 1'b1) break;
			if (sel == 1 && tx_busy_reg === 1'b0) break;
			if (sel == 2 && i_uart9_remote.got_q.size() > 0) break;
			tick(1);
		end
		if (k == 20000) begin
			err_count++;
			$display("[ERR] %0t wait %0d timed out", $time, sel);
			summarize();
		end
	endtask
	task automatic push(input logic [7:0] v, input int n);
		serial_buffer_wr = 1'b1;
		for (int i = 0; i < n; i++) begin
			serial_buffer_wr_data = v + 8'(i);
			tick(1);
		end
		serial_buffer_wr = 1'b0;
	endtask
	task automatic clr;
		tx_done_clr = 1'b1;
		rx_done_clr = 1'b1;
		tick(1);
		tx_done_clr = 1'b0;
		rx_done_clr = 1'b0;
		tick(1);
	endtask
	// Remote sends one frame, then flag, ninth bit and buffer are compared
	task automatic rx_case(input logic en, input logic filt, input logic [8:0] ch,
		input logic stp, input logic [9:0] exp);
		rx_enable = en;
		address_filter_mode = filt;
		i_uart9_remote.send(ch, stp);
		tick(send_clks);
		check({rx_done_flag_reg, ninth_rx_bit_reg, serial_buffer_rx_reg}, exp);
	endtask
	// ==========================================
	// Main sequence
	initial begin
		tick(3);
		rst_b = 1'b1;
		check({tx_pin_reg, tx_done_flag_reg, rx_done_flag_reg, serial_buffer_wr_ready,
			tx_busy_reg, baud_double_reg, 4'h0}, 10'h240);
		check({2'h0, serial_buffer_rx_reg}, 10'h000);
		rx_case(1'b0, 1'b0, 9'h111, 1'b1, 10'h000);
		rx_case(1'b1, 1'b1, 9'h022, 1'b1, 10'h000);
		rx_case(1'b1, 1'b1, 9'h133, 1'b0, 10'h333);
		check({9'h0, serial_irq_reg}, 10'h001);
		rx_case(1'b1, 1'b0, 9'h044, 1'b1, 10'h333);
		clr();
		check({9'h0, rx_done_flag_reg}, 10'h000);
		$display("test receive rules done");
		serial_int_enable = 1'b0;
		{mode_sel_hi, mode_sel_lo} = 2'b00;
		push(8'h10, FIFO_DEPTH / 2);
		tick(1);
		{mode_sel_hi, mode_sel_lo} = 2'b01;
		push(8'h18, FIFO_DEPTH / 2 + 1);
		check({serial_buffer_wr_ready, tx_busy_reg, tx_pin_reg,
			7'(i_uart9_remote.got_q.size())}, 10'h180);
		{mode_sel_hi, mode_sel_lo} = 2'b10;
		wait_on(1);
		tick(8);
		check(10'(i_uart9_remote.got_q.size()), 10'(FIFO_DEPTH));
		for (int i = 0; i < FIFO_DEPTH; i++)
			check(i_uart9_remote.got_q.pop_front(), {2'b10, 8'h10 + 8'(i)});
		check({8'h0, tx_done_flag_reg, serial_irq_reg}, 10'h002);
		serial_int_enable = 1'b1;
		clr();
		$display("test buffer fill done");
		for (int i = 0; i < 8; i++) begin
			r = rows[i];
			{mode_sel_hi, mode_sel_lo, baud_double, timer1_tick_select} = {1'b1, r.m3, r.dbl, r.tick};
			reload_hi = r.rl;
			{rx_clock_select, tx_clock_select, t2_counter_select} = {r.rc, r.tc, r.cs};
			{t2_reload_high, t2_reload_low} = r.t2;
			recv_clks = r.txc;
			send_clks = r.rxc;
			b = 8'h5A ^ 8'(i * 17);
			ninth_tx_bit = i[0];
			tick(2);
			check({8'h0, baud_double_reg, t2_irq_block_reg},
				{8'h0, r.dbl, r.rc | r.tc});
			push(b, 1);
			wait_on(0);
			wait_on(2);
			check(i_uart9_remote.got_q.pop_front(), {1'b1, i[0], b});
			wait_on(1);
			rx_case(1'b1, 1'b0, {~i[0], ~b}, 1'b1, {1'b1, ~i[0], ~b});
			clr();
			$display("test rate row %0d done", i);
		end
		summarize();
	end
endmodule
